// ==== eeemr_regs.sv ====
// How it works
// RULE_01 - Capability bit 2 reads zero: no low-power mode at gigabit.
// RULE_02 - Capability bit 1 reads one: low-power mode supported at 100 Mbps.
// RULE_03 - Sixteen-bit counter counts each wake sequence that overruns its time.
// RULE_04 - Reading the wake fault counter returns its value then clears it.
// RULE_05 - Wake fault counter holds at all ones instead of wrapping.
// RULE_06 - Coding sublayer soft reset also clears the wake fault counter.
// RULE_07 - Advertisement bit 1 is read/write, resets to zero, advertises 100 Mbps.
// RULE_08 - Partner ability bit 1 mirrors partner's 100 Mbps advert, resets to zero.
// RULE_09 - System supplies a 25 MHz reference, or 50 MHz in reduced-MII slave mode.
// RULE_10 - Unused bits of capability, advertisement and partner registers read zero.
// RULE_11 - Self-clearing soft reset bit resets these groups, not vendor registers.
// RULE_12 - Low-power idle at 100 Mbps only when both adverts set after negotiation.
module eeemr_regs #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire eeemr_pkg::eeemr_req_type req,
  input wire logic wake_fault,
  input wire logic partner_lowpower_advert_in,
  input wire logic partner_advert_valid,
  input wire logic autoneg_done,
  input wire logic link_100m,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic lowpower_idle_enable,
  output logic coding_sublayer_soft_reset
);

  // The read port and the saturation limit are fixed at sixteen bits
  if (COUNT_WIDTH != 16) begin : g_width_check
    $error("eeemr_regs: COUNT_WIDTH must be 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic rd_cap, rd_cnt, rd_adv, rd_lp, rd_ctrl, wr_adv, wr_ctrl, soft_rst;
  logic [15:0] wake_fault_count_r;
  logic local_lowpower_advert_r;
  logic partner_lowpower_advert_r;
  logic [15:0] rdata_nxt;

  assign rd_cap = req.rd && req.addr == eeemr_pkg::EEE_CAPABILITY_OFFSET;
  assign rd_cnt = req.rd && req.addr == eeemr_pkg::WAKE_ERROR_COUNT_OFFSET;
  assign rd_adv = req.rd && req.addr == eeemr_pkg::EEE_ADVERTISEMENT_OFFSET;
  assign rd_lp = req.rd && req.addr == eeemr_pkg::PARTNER_EEE_ABILITY_OFFSET;
  assign rd_ctrl = req.rd && req.addr == eeemr_pkg::PCS_CTRL_OFFSET;
  assign wr_adv = req.wr && req.addr == eeemr_pkg::EEE_ADVERTISEMENT_OFFSET;
  assign wr_ctrl = req.wr && req.addr == eeemr_pkg::PCS_CTRL_OFFSET;
  // Soft reset acts in the cycle the bit is written; the bit reads back zero
  assign soft_rst = wr_ctrl && req.wdata[eeemr_pkg::SOFT_RESET_BIT]; // RULE_11

  ////////////////////////////////////////////////////////////////////////////
  // Wake fault counter

  always_ff @(posedge clk) begin
    if (!reset_n || soft_rst) begin
      wake_fault_count_r <= eeemr_pkg::WAKE_ERROR_COUNT_RESET; // RULE_06
    end else if (rd_cnt) begin
      // A fault in the read cycle is kept: it counts as one after clearing
      wake_fault_count_r <= {15'h0000, wake_fault}; // RULE_04
    end else if (wake_fault && wake_fault_count_r != eeemr_pkg::WAKE_ERROR_COUNT_MAX) begin // RULE_05
      wake_fault_count_r <= wake_fault_count_r + 16'h0001; // RULE_03
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Advertisement and partner ability

  always_ff @(posedge clk) begin
    if (!reset_n || soft_rst) begin
      local_lowpower_advert_r <= eeemr_pkg::EEE_ADVERTISEMENT_RESET[1];
    end else if (wr_adv) begin
      local_lowpower_advert_r <= req.wdata[eeemr_pkg::LOCAL_ADVERT_BIT]; // RULE_07
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || soft_rst) begin
      partner_lowpower_advert_r <= eeemr_pkg::PARTNER_EEE_ABILITY_RESET[1];
    end else if (partner_advert_valid) begin
      partner_lowpower_advert_r <= partner_lowpower_advert_in; // RULE_08
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lowpower_idle_enable <= 1'b0;
    end else begin
      lowpower_idle_enable <= autoneg_done && link_100m && !soft_rst &&
        local_lowpower_advert_r && partner_lowpower_advert_r; // RULE_12
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      coding_sublayer_soft_reset <= 1'b0;
    end else begin
      coding_sublayer_soft_reset <= soft_rst; // RULE_11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    rdata_nxt = 16'h0000; // RULE_10
    if (rd_cap) begin
      rdata_nxt[eeemr_pkg::GIGABIT_LOWPOWER_BIT] = eeemr_pkg::GIGABIT_LOWPOWER_RESET; // RULE_01
      rdata_nxt[eeemr_pkg::FAST_LOWPOWER_BIT] = eeemr_pkg::FAST_LOWPOWER_RESET; // RULE_02
    end else if (rd_cnt) begin
      rdata_nxt = wake_fault_count_r; // RULE_04
    end else if (rd_adv) begin
      rdata_nxt[eeemr_pkg::LOCAL_ADVERT_BIT] = local_lowpower_advert_r; // RULE_07
    end else if (rd_lp) begin
      rdata_nxt[eeemr_pkg::PARTNER_ADVERT_BIT] = partner_lowpower_advert_r; // RULE_08
    end else if (rd_ctrl) begin
      rdata_nxt = 16'h0000; // RULE_11
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rdata <= rdata_nxt;
      rvalid <= req.rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  cap_read_value_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
    rd_cap |=> rdata == eeemr_pkg::EEE_CAPABILITY_RESET && rvalid)
    else $error("capability read value wrong");

  fast_supported_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_02
    rd_cap |=> rdata[1] && !rdata[2])
    else $error("capability bits wrong");

  count_incr_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
    (wake_fault && !rd_cnt && !soft_rst && wake_fault_count_r != 16'hFFFF)
    |=> wake_fault_count_r == $past(wake_fault_count_r) + 16'h0001)
    else $error("wake fault count did not increment");

  read_clears_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
    (rd_cnt && !wake_fault) |=> wake_fault_count_r == 16'h0000 &&
      rdata == $past(wake_fault_count_r))
    else $error("read did not return then clear count");

  count_saturate_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
    (wake_fault_count_r == 16'hFFFF && !rd_cnt && !soft_rst) |=> wake_fault_count_r == 16'hFFFF)
    else $error("wake fault count wrapped");

  soft_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_06
    soft_rst |=> wake_fault_count_r == 16'h0000 && !local_lowpower_advert_r)
    else $error("soft reset did not clear registers");

  advert_write_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_07
    (wr_adv && !soft_rst) |=>
      local_lowpower_advert_r == $past(req.wdata[eeemr_pkg::LOCAL_ADVERT_BIT]))
    else $error("advertisement write not captured");

  partner_track_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_08
    (partner_advert_valid && !soft_rst) |=> partner_lowpower_advert_r ==
      $past(partner_lowpower_advert_in))
    else $error("partner ability not captured");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
    (rd_adv || rd_lp) |=> rdata[15:2] == 14'h0000 && !rdata[0])
    else $error("reserved bits not zero");

  soft_pulse_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
    coding_sublayer_soft_reset |-> $past(soft_rst) && !lowpower_idle_enable)
    else $error("soft reset pulse wrong");

  lpi_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_12
    lowpower_idle_enable |-> $past(local_lowpower_advert_r && partner_lowpower_advert_r
      && autoneg_done && link_100m))
    else $error("low-power idle enabled without both adverts");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on reset, read port and register state

  reset_clears_a: assert property (@(posedge clk) // RULE_07
    !reset_n |=> !local_lowpower_advert_r && !partner_lowpower_advert_r &&
      wake_fault_count_r == eeemr_pkg::WAKE_ERROR_COUNT_RESET && !rvalid)
    else $error("registers not cleared by reset");

  reset_outputs_a: assert property (@(posedge clk) // RULE_12
    !reset_n |=>
      rdata == 16'h0000 && !lowpower_idle_enable && !coding_sublayer_soft_reset)
    else $error("outputs not quiet after reset");

  gig_unsupported_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_01
    rd_cap |=>
      !rdata[eeemr_pkg::GIGABIT_LOWPOWER_BIT] && rvalid)
    else $error("gigabit low-power bit set");

  cap_reserved_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
    rd_cap |=>
      rdata[15:3] == 13'h0000 && !rdata[0])
    else $error("capability reserved bits not zero");

  read_answer_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
    req.rd |=>
      rvalid)
    else $error("read not answered");

  answer_pulse_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
    !req.rd |=>
      !rvalid && rdata == 16'h0000)
    else $error("read answer outside a read");

  count_readback_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
    rd_cnt |=>
      rdata == $past(wake_fault_count_r) && rvalid)
    else $error("wake fault count read wrong");

  fault_kept_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_04
    (rd_cnt && wake_fault && !soft_rst) |=>
      wake_fault_count_r == 16'h0001)
    else $error("fault during read lost");

  count_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
    (!wake_fault && !rd_cnt && !soft_rst) |=>
      $stable(wake_fault_count_r))
    else $error("wake fault count moved without a fault");

  count_no_wrap_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_05
    (wake_fault && !rd_cnt && !soft_rst && wake_fault_count_r == 16'hFFFF) |=>
      wake_fault_count_r == 16'hFFFF)
    else $error("wake fault count left all ones");

  fault_counted_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_03
    (wake_fault && !soft_rst) |=>
      wake_fault_count_r != 16'h0000)
    else $error("wake fault not counted");

  soft_partner_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
    soft_rst |=>
      !partner_lowpower_advert_r)
    else $error("soft reset kept partner bit");

  soft_lpi_off_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
    soft_rst |=>
      !lowpower_idle_enable)
    else $error("low-power idle on after soft reset");

  soft_pulse_set_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
    soft_rst |=>
      coding_sublayer_soft_reset)
    else $error("soft reset pulse missing");

  soft_self_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
    !soft_rst |=>
      !coding_sublayer_soft_reset)
    else $error("soft reset pulse did not clear");

  ctrl_reads_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_11
    rd_ctrl |=>
      rdata == 16'h0000 && rvalid)
    else $error("control register read not zero");

  advert_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_07
    (!wr_adv && !soft_rst) |=>
      $stable(local_lowpower_advert_r))
    else $error("advertisement changed without a write");

  advert_read_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_07
    rd_adv |=>
      rdata == {14'h0000, $past(local_lowpower_advert_r), 1'b0})
    else $error("advertisement readback wrong");

  partner_read_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_08
    rd_lp |=>
      rdata == {14'h0000, $past(partner_lowpower_advert_r), 1'b0})
    else $error("partner ability readback wrong");

  partner_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_08
    (!partner_advert_valid && !soft_rst) |=>
      $stable(partner_lowpower_advert_r))
    else $error("partner bit changed without capture");

  lpi_on_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_12
    (local_lowpower_advert_r && partner_lowpower_advert_r && autoneg_done && link_100m &&
      !soft_rst) |=> lowpower_idle_enable)
    else $error("low-power idle not enabled");

  lpi_off_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_12
    !(autoneg_done && link_100m) |=>
      !lowpower_idle_enable)
    else $error("low-power idle on without 100 Mbps link");

  unmapped_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_10
    (req.rd && !rd_cap && !rd_cnt && !rd_adv && !rd_lp && !rd_ctrl) |=>
      rdata == 16'h0000 && rvalid)
    else $error("unmapped read not zero");

  write_no_answer_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE_07
    (req.wr && !req.rd) |=>
      !rvalid)
    else $error("write produced a read answer");

endmodule : eeemr_regs

// ==== eeemr_pkg.sv ====
package eeemr_pkg;

  // Register offsets (extended management address space)
  localparam logic [15:0] PCS_CTRL_OFFSET = 16'h1000;
  localparam logic [15:0] EEE_CAPABILITY_OFFSET = 16'h1014;
  localparam logic [15:0] WAKE_ERROR_COUNT_OFFSET = 16'h1016;
  localparam logic [15:0] EEE_ADVERTISEMENT_OFFSET = 16'h203C;
  localparam logic [15:0] PARTNER_EEE_ABILITY_OFFSET = 16'h203D;

  // Field positions
  localparam int GIGABIT_LOWPOWER_BIT = 2;
  localparam int FAST_LOWPOWER_BIT = 1;
  localparam int LOCAL_ADVERT_BIT = 1;
  localparam int PARTNER_ADVERT_BIT = 1;
  localparam int SOFT_RESET_BIT = 15;

  // Reset values and wake fault counter saturation limit
  localparam logic [15:0] EEE_CAPABILITY_RESET = 16'h0002;
  localparam logic [15:0] WAKE_ERROR_COUNT_RESET = 16'h0000;
  localparam logic [15:0] WAKE_ERROR_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] EEE_ADVERTISEMENT_RESET = 16'h0000;
  localparam logic [15:0] PARTNER_EEE_ABILITY_RESET = 16'h0000;
  localparam logic GIGABIT_LOWPOWER_RESET = 1'b0;
  localparam logic FAST_LOWPOWER_RESET = 1'b1;

  // Management access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } eeemr_req_type;

endpackage : eeemr_pkg

// ==== eeemr_host.sv ====
module eeemr_host (
  input wire logic clk,
  output eeemr_pkg::eeemr_req_type req,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // Released bus lines show inverted address and data
  task automatic idle();
    req <= '{rd: 1'b0, wr: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
  endtask : idle
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    idle();
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~req.wdata};
    @(posedge clk);
    idle();
    #1;
    d = rdata;
    v = rvalid;
  endtask : rd
endmodule : eeemr_host

// ==== test_eeemr_regs.sv ====
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module test_eeemr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wake_fault = 1'b0;
  logic p_adv = 1'b0;
  logic p_vld = 1'b0;
  logic an_done = 1'b0;
  logic link_100m = 1'b0;
  eeemr_pkg::eeemr_req_type req;
  logic [15:0] rdata;
  logic rvalid;
  logic lpi_en;
  logic sr_pulse;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  eeemr_regs dut (.clk(clk), .reset_n(reset_n), .req(req), .wake_fault(wake_fault),
    .partner_lowpower_advert_in(p_adv), .partner_advert_valid(p_vld),
    .autoneg_done(an_done), .link_100m(link_100m), .rdata(rdata), .rvalid(rvalid),
    .lowpower_idle_enable(lpi_en), .coding_sublayer_soft_reset(sr_pulse));
  eeemr_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic rchk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic v;
    host.rd(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask : rchk
  task automatic pulse(input int n);
    repeat (n) @(posedge clk) wake_fault <= 1'b1;
    @(posedge clk) wake_fault <= 1'b0;
  endtask : pulse
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rchk(16'h1014, 16'h0002);
    rchk(16'h1016, 16'h0000);
    rchk(16'h203C, 16'h0000);
    rchk(16'h203D, 16'h0000);
    rchk(16'h1234, 16'h0000);
    host.wr(16'h1014, 16'hFFFF);
    rchk(16'h1014, 16'h0002);
    host.wr(16'h203C, 16'hFFFF);
    rchk(16'h203C, 16'h0002);
  endtask : t_reset_values
  task automatic t_wake();
    pulse(3);
    rchk(16'h1016, 16'h0003);
    rchk(16'h1016, 16'h0000);
  endtask : t_wake
  task automatic t_read_race();
    logic [15:0] d;
    logic v;
    pulse(1);
    fork
      host.rd(16'h1016, d, v);
      begin
        @(posedge clk) wake_fault <= 1'b1;
        @(posedge clk) wake_fault <= 1'b0;
      end
    join
    `CHK("rvalid", 1'b1, v)
    `CHK("count", 16'h0001, d)
    rchk(16'h1016, 16'h0001);
  endtask : t_read_race
  task automatic t_partner_lpi();
    @(posedge clk) {p_adv, p_vld} <= 2'b11;
    @(posedge clk) p_vld <= 1'b0;
    rchk(16'h203D, 16'h0002);
    @(posedge clk) {an_done, link_100m} <= 2'b11;
    settle();
    `CHK("lpi", 1'b1, lpi_en)
    @(posedge clk) link_100m <= 1'b0;
    settle();
    `CHK("lpi", 1'b0, lpi_en)
  endtask : t_partner_lpi
  task automatic t_soft_reset();
    pulse(2);
    host.wr(16'h1000, 16'h8000);
    `CHK("soft reset", 1'b1, sr_pulse)
    @(posedge clk);
    #1;
    `CHK("soft reset", 1'b0, sr_pulse)
    rchk(16'h1016, 16'h0000);
    rchk(16'h203C, 16'h0000);
    rchk(16'h203D, 16'h0000);
    rchk(16'h1000, 16'h0000);
  endtask : t_soft_reset
  task automatic t_saturate();
    pulse(65540);
    rchk(16'h1016, 16'hFFFF);
    rchk(16'h1016, 16'h0000);
  endtask : t_saturate
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset_values();
    t_wake();
    t_read_race();
    t_partner_lpi();
    t_soft_reset();
    t_saturate();
    tally_and_finish();
  end
endmodule : test_eeemr_regs
